// >>> rtl/fpse_sequencer.sv
`default_nettype none
module fpse_sequencer
	import fpse_pkg::*;
(
	input  wire logic                      ref_clk_in,
	input  wire logic                      rstn_in,
	input  wire logic                      clk_en_in,
	input  wire fpse_pkg::fpse_bus_t       bus_in,
	input  wire logic                      wr_en_in,
	input  wire logic                      ce_n_in,
	input  wire logic                      oe_n_in,
	input  wire logic [fpse_pkg::DATA_W-1:0] array_data_in,
	input  wire logic [fpse_pkg::DATA_W-1:0] query_data_in,
	input  wire logic                      engine_busy_in,
	input  wire logic                      engine_done_in,
	input  wire logic                      erase_fail_in,
	input  wire logic                      chip_op_busy_in,
	input  wire logic [fpse_pkg::PART_COUNT-1:0] prog_busy_in,
	input  wire logic [fpse_pkg::PART_COUNT-1:0] prog_err_in,
	input  wire logic [fpse_pkg::PART_COUNT-1:0] erase_susp_in,
	input  wire logic [fpse_pkg::PART_COUNT-1:0] prog_susp_in,
	input  wire logic                      supply_low_in,
	input  wire logic                      block_locked_in,
	input  wire logic                      buffer_avail_in,
	output logic [fpse_pkg::DATA_W-1:0]    rdata_out,
	output logic                           dq_oe_n_out,
	output logic                           erase_start_out,
	output fpse_pkg::fpse_erase_req_t      erase_req_out
);
	import fpse_pkg::*;

	// ==========================================================
	// State
	fpse_mode_t            mode_reg     [PART_COUNT];
	logic [ERR_W-1:0]      err_reg      [PART_COUNT];
	logic [PART_COUNT-1:0] erasing_reg;
	logic [PART_COUNT-1:0] xsr_avail_reg;
	logic                  setup_reg;
	logic [ADDR_W-1:0]     setup_addr_reg;
	logic                  read_act_reg;
	logic [DATA_W-1:0]     rdata_reg;
	logic                  start_reg;
	fpse_erase_req_t       req_reg;

	// ==========================================================
	// Write decode
	logic [PART_W-1:0]     wr_part;
	logic [PART_W-1:0]     setup_part;
	logic [7:0]            cmd;
	logic                  cmd_wr;
	logic                  confirm_wr;
	logic                  confirm_ok;
	logic                  erase_go;
	logic [ERR_W-1:0]      erase_err;
	logic [PART_COUNT-1:0] part_busy;
	logic [PART_COUNT-1:0] part_susp;

	assign wr_part    = bus_in.addr[PART_POS +: PART_W];
	assign setup_part = setup_addr_reg[PART_POS +: PART_W];
	assign cmd        = bus_in.data[7:0];
	// While an erase setup is pending the next write is its confirm cycle,
	// whatever byte it carries, so it is not decoded as a new command.
	assign cmd_wr     = wr_en_in & ~setup_reg;
	assign confirm_wr = wr_en_in & setup_reg;
	assign confirm_ok = confirm_wr & (cmd == CMD_CONFIRM)
		& (bus_in.addr == setup_addr_reg);
	assign part_busy  = erasing_reg | prog_busy_in;
	assign part_susp  = erase_susp_in | prog_susp_in;

	// Supply and lock are looked at only here, at confirm time
	always_comb begin
		erase_err = ERR_RESET;
		erase_go  = 1'b0;
		if (confirm_wr) begin
			if (!confirm_ok) begin
				erase_err[ERR_ERASE] = 1'b1;
				erase_err[ERR_PROG]  = 1'b1;
			end else if (supply_low_in) begin
				erase_err[ERR_ERASE]  = 1'b1;
				erase_err[ERR_SUPPLY] = 1'b1;
			end else if (block_locked_in) begin
				erase_err[ERR_ERASE]  = 1'b1;
				erase_err[ERR_LOCKED] = 1'b1;
			end else if (engine_busy_in || chip_op_busy_in) begin
				// Engine taken elsewhere: refused as an improper sequence
				erase_err[ERR_ERASE] = 1'b1;
				erase_err[ERR_PROG]  = 1'b1;
			end else begin
				erase_go = 1'b1;
			end
		end
	end

	// ==========================================================
	// Erase setup and engine request
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			setup_reg      <= 1'b0;
			setup_addr_reg <= ADDR_RESET;
		end else if (clk_en_in) begin
			if (confirm_wr) begin
				setup_reg <= 1'b0;
			end else if (cmd_wr && cmd == CMD_ERASE_SETUP) begin
				setup_reg      <= 1'b1;
				setup_addr_reg <= bus_in.addr;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			start_reg <= 1'b0;
			req_reg   <= '0;
		end else if (clk_en_in) begin
			start_reg <= erase_go;
			if (erase_go) begin
				req_reg.part  <= setup_part;
				req_reg.block <= setup_addr_reg[BLOCK_POS +: BLOCK_W];
			end
		end
	end

	assign erase_start_out = start_reg;
	assign erase_req_out   = req_reg;

	// ==========================================================
	// Per-partition mode, errors and extended status
	genvar p;
	generate
		for (p = 0; p < PART_COUNT; p++) begin : g_part
			logic hit;
			logic setup_hit;
			logic [ERR_W-1:0] err_set;
			logic err_clr;

			assign hit       = cmd_wr & (wr_part == PART_W'(p));
			assign setup_hit = confirm_wr & (setup_part == PART_W'(p));
			// Clear refused while suspended; no supply check on it
			assign err_clr   = hit & (cmd == CMD_CLEAR_STATUS)
				& ~part_susp[p];

			always_comb begin
				err_set = setup_hit ? erase_err : ERR_RESET;
				if (prog_err_in[p]) begin
					err_set[ERR_PROG] = 1'b1;
				end
				if (engine_done_in && erase_fail_in && erasing_reg[p]) begin
					err_set[ERR_ERASE] = 1'b1;
				end
			end

			// A new error in the clearing cycle survives the clear
			always_ff @(posedge ref_clk_in) begin
				if (!rstn_in) begin
					err_reg[p] <= ERR_RESET;
				end else if (clk_en_in) begin
					err_reg[p] <= (err_reg[p] & {ERR_W{~err_clr}})
						| err_set;
				end
			end

			always_ff @(posedge ref_clk_in) begin
				if (!rstn_in) begin
					erasing_reg[p] <= 1'b0;
				end else if (clk_en_in) begin
					if (erase_go && setup_part == PART_W'(p)) begin
						erasing_reg[p] <= 1'b1;
					end else if (engine_done_in) begin
						erasing_reg[p] <= 1'b0;
					end
				end
			end

			always_ff @(posedge ref_clk_in) begin
				if (!rstn_in) begin
					xsr_avail_reg[p] <= 1'b0;
				end else if (clk_en_in && hit && cmd == CMD_PAGE_BUFFER) begin
					xsr_avail_reg[p] <= buffer_avail_in;
				end
			end

			always_ff @(posedge ref_clk_in) begin
				if (!rstn_in) begin
					mode_reg[p] <= FPSE_MODE_ARRAY;
				end else if (clk_en_in) begin
					if (setup_hit) begin
						mode_reg[p] <= FPSE_MODE_STATUS;
					end else if (hit) begin
						case (cmd)
							CMD_READ_QUERY: begin
								if (!(part_busy[p] && !part_susp[p])
									&& !chip_op_busy_in) begin
									mode_reg[p] <= FPSE_MODE_QUERY;
								end
							end
							CMD_READ_STATUS: begin
								mode_reg[p] <= FPSE_MODE_STATUS;
							end
							CMD_CLEAR_STATUS: begin
								if (!part_susp[p]) begin
									mode_reg[p] <= FPSE_MODE_ARRAY;
								end
							end
							CMD_READ_ARRAY: begin
								// Busy partitions keep answering status below
								mode_reg[p] <= FPSE_MODE_ARRAY;
							end
							CMD_ERASE_SETUP: begin
								mode_reg[p] <= FPSE_MODE_STATUS;
							end
							CMD_PAGE_BUFFER: begin
								mode_reg[p] <= FPSE_MODE_XSTATUS;
							end
							default: begin
								mode_reg[p] <= mode_reg[p];
							end
						endcase
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Status words
	function automatic logic [DATA_W-1:0] status_word(input logic ready,
		input logic esusp, input logic psusp, input logic [ERR_W-1:0] err);
		logic [DATA_W-1:0] w;
		w = WORD_RESET;
		w[SR_READY_POS]      = ready;
		w[SR_ERASE_SUSP_POS] = esusp;
		w[SR_ERASE_ERR_POS]  = err[ERR_ERASE];
		w[SR_PROG_ERR_POS]   = err[ERR_PROG];
		w[SR_SUPPLY_POS]     = err[ERR_SUPPLY];
		w[SR_PROG_SUSP_POS]  = psusp;
		w[SR_LOCKED_POS]     = err[ERR_LOCKED];
		return w;
	endfunction

	// ==========================================================
	// Read path
	logic [PART_W-1:0] rd_part;
	logic              read_act;
	logic              read_start;
	logic              show_status;
	logic              latch_once;
	fpse_mode_t        rd_mode;
	logic [DATA_W-1:0] sel_data;
	logic [DATA_W-1:0] xsr_word;

	assign rd_part    = bus_in.addr[PART_POS +: PART_W];
	assign rd_mode    = mode_reg[rd_part];
	assign read_act   = ~ce_n_in & ~oe_n_in;
	assign read_start = read_act & ~read_act_reg;
	// Whole-device operations put every partition on status
	assign show_status = chip_op_busy_in | part_busy[rd_part]
		| (rd_mode == FPSE_MODE_STATUS);
	assign latch_once  = show_status | (rd_mode == FPSE_MODE_XSTATUS);

	always_comb begin
		xsr_word = WORD_RESET;
		xsr_word[XSR_BUFFER_POS] = xsr_avail_reg[rd_part];
		if (show_status) begin
			// Ready is this partition's busy plus whole-device operations, not the shared engine
			sel_data = status_word(~part_busy[rd_part] & ~chip_op_busy_in,
				erase_susp_in[rd_part], prog_susp_in[rd_part],
				err_reg[rd_part]);
		end else begin
			case (rd_mode)
				FPSE_MODE_QUERY:   sel_data = query_data_in;
				FPSE_MODE_XSTATUS: sel_data = xsr_word;
				default:           sel_data = array_data_in;
			endcase
		end
	end

	// Status is frozen for the whole read; the host must raise an enable
	// to see fresh status. Only single reads are served, so no page or
	// burst sequencing exists here.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			read_act_reg <= 1'b0;
			rdata_reg    <= WORD_RESET;
		end else if (clk_en_in) begin
			read_act_reg <= read_act;
			if (read_start || (read_act && !latch_once)) begin
				rdata_reg <= sel_data;
			end
		end
	end

	assign rdata_out   = rdata_reg;
	assign dq_oe_n_out = ~read_act_reg;

endmodule
`default_nettype wire

// >>> rtl/fpse_pkg.sv
`default_nettype none
package fpse_pkg;

	// ==========================================================
	// Geometry
	localparam int PART_COUNT = 4;
	localparam int PART_W     = 2;
	localparam int ADDR_W     = 21;
	localparam int DATA_W     = 16;
	localparam int PART_POS   = 19;
	localparam int BLOCK_W    = 6;
	localparam int BLOCK_POS  = 15;

	// ==========================================================
	// Command bytes
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
	localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
	localparam logic [7:0] CMD_PAGE_BUFFER  = 8'he8;

	// ==========================================================
	// Status word layout
	localparam int SR_READY_POS      = 7;
	localparam int SR_ERASE_SUSP_POS = 6;
	localparam int SR_ERASE_ERR_POS  = 5;
	localparam int SR_PROG_ERR_POS   = 4;
	localparam int SR_SUPPLY_POS     = 3;
	localparam int SR_PROG_SUSP_POS  = 2;
	localparam int SR_LOCKED_POS     = 1;
	localparam int XSR_BUFFER_POS    = 7;

	// Sticky error bits, kept per partition in this order
	localparam int ERR_W      = 4;
	localparam int ERR_ERASE  = 3;
	localparam int ERR_PROG   = 2;
	localparam int ERR_SUPPLY = 1;
	localparam int ERR_LOCKED = 0;

	// ==========================================================
	// Reset values
	localparam logic [ERR_W-1:0]  ERR_RESET  = 4'h0;
	localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;

	typedef enum logic [1:0] {
		FPSE_MODE_ARRAY,
		FPSE_MODE_STATUS,
		FPSE_MODE_QUERY,
		FPSE_MODE_XSTATUS
	} fpse_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fpse_bus_t;

	typedef struct packed {
		logic [PART_W-1:0]  part;
		logic [BLOCK_W-1:0] block;
	} fpse_erase_req_t;

endpackage
`default_nettype wire

// >>> test/fpse_sequencer_checker.sv
`default_nettype none
// ==========================================================
// Port checker
module fpse_sequencer_checker
	import fpse_pkg::*;
(
	input  wire logic                      ref_clk_in,
	input  wire logic                      rstn_in,
	input  wire logic                      clk_en_in,
	input  wire fpse_pkg::fpse_bus_t       bus_in,
	input  wire logic                      wr_en_in,
	input  wire logic                      ce_n_in,
	input  wire logic                      oe_n_in,
	input  wire logic                      engine_busy_in,
	input  wire logic                      chip_op_busy_in,
	input  wire logic [3:0]                erase_susp_in,
	input  wire logic                      supply_low_in,
	input  wire logic                      block_locked_in,
	input  wire logic [15:0]               rdata_out,
	input  wire logic                      dq_oe_n_out,
	input  wire logic                      erase_start_out,
	input  wire fpse_pkg::fpse_erase_req_t erase_req_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_in); endclocking
	// Frozen cycles would look like stretched pulses
	default disable iff (!rstn_in || !clk_en_in);

	sequence setup_s;
		wr_en_in && bus_in.data[7:0] == CMD_ERASE_SETUP;
	endsequence
	sequence confirm_s;
		wr_en_in && bus_in.data[7:0] == CMD_CONFIRM && bus_in.addr == $past(bus_in.addr, 2)
			&& !supply_low_in && !block_locked_in && !engine_busy_in && !chip_op_busy_in;
	endsequence
	sequence read_start_s;
		$fell(ce_n_in | oe_n_in) && chip_op_busy_in;
	endsequence

	erase_launch_a: assert property (setup_s ##1 !wr_en_in ##1 confirm_s |=> erase_start_out)
		else $error("valid erase pair did not launch");
	start_pulse_a: assert property (erase_start_out |=> !erase_start_out)
		else $error("erase start longer than one cycle");
	start_cause_a: assert property (erase_start_out |-> $past(wr_en_in &&
		bus_in.data[7:0] == CMD_CONFIRM && !supply_low_in && !block_locked_in))
		else $error("erase start without clean confirm");
	req_addr_a: assert property (erase_start_out |->
		erase_req_out == {$past(bus_in.addr[20:19]), $past(bus_in.addr[20:15])})
		else $error("erase target differs from address");
	req_hold_a: assert property (!erase_start_out && $past(rstn_in) |-> $stable(erase_req_out))
		else $error("erase target moved without start");
	drive_timing_a: assert property ($past(rstn_in) |-> dq_oe_n_out == $past(ce_n_in | oe_n_in))
		else $error("data drive enable mistimed");
	busy_status_a: assert property (read_start_s |=> rdata_out[15:8] == 8'h00
		&& !rdata_out[SR_READY_POS] && !rdata_out[0])
		else $error("status during chip operation wrong");
	susp_bit_a: assert property (read_start_s |=>
		rdata_out[SR_ERASE_SUSP_POS] == $past(erase_susp_in[bus_in.addr[20:19]]))
		else $error("suspend flag not from addressed partition");
	status_freeze_a: assert property (!(ce_n_in | oe_n_in) && $past(!(ce_n_in | oe_n_in))
		&& chip_op_busy_in && $past(chip_op_busy_in) |=> $stable(rdata_out))
		else $error("status changed within one read");
endmodule

bind fpse_sequencer fpse_sequencer_checker u_fpse_sequencer_checker (.ref_clk_in, .rstn_in,
	.clk_en_in, .bus_in, .wr_en_in, .ce_n_in, .oe_n_in, .engine_busy_in, .chip_op_busy_in,
	.erase_susp_in, .supply_low_in, .block_locked_in, .rdata_out, .dq_oe_n_out,
	.erase_start_out, .erase_req_out);
`default_nettype wire

// >>> test/fpse_engine_model.sv
`default_nettype none
// ==========================================================
// Shared write engine seen from the sequencer
module fpse_engine_model #(
	parameter int LAT = 60
) (
	input  wire logic ref_clk_in,
	input  wire logic rstn_in,
	input  wire logic start_in,
	input  wire logic fail_mode_in,
	output logic      busy_out,
	output logic      done_out,
	output logic      fail_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_reg;
	// One engine for all partitions, so a single busy flag
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			busy_out <= 1'b0;
			done_out <= 1'b0;
			fail_out <= 1'b0;
			cnt_reg  <= 8'h00;
		end else if (start_in) begin
			busy_out <= 1'b1;
			cnt_reg  <= 8'(LAT);
		end else if (busy_out && cnt_reg == 8'h00) begin
			busy_out <= 1'b0;
			done_out <= 1'b1;
			fail_out <= fail_mode_in;
		end else begin
			done_out <= 1'b0;
			fail_out <= 1'b0;
			cnt_reg  <= cnt_reg - 8'h01;
		end
	end
endmodule
`default_nettype wire

// >>> test/flash_partition_status_and_erase_test.sv
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module flash_partition_status_and_erase_test
	import fpse_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [20:0] P0 = 21'h000010, P1 = 21'h080020;
	localparam logic [20:0] P2 = 21'h100040, P3 = 21'h188100;
	localparam logic [15:0] RDY = 16'h0001 << SR_READY_POS, EE = 16'h0001 << SR_ERASE_ERR_POS;
	localparam logic [15:0] PE = 16'h0001 << SR_PROG_ERR_POS, SL = 16'h0001 << SR_SUPPLY_POS;
	localparam logic [15:0] LK = 16'h0001 << SR_LOCKED_POS, ES = 16'h0001 << SR_ERASE_SUSP_POS;
	localparam logic [15:0] BUF = 16'h0001 << XSR_BUFFER_POS, PS = 16'h0001 << SR_PROG_SUSP_POS;
	logic ref_clk_in = 0, rstn_in = 0, wr_en_in = 0, ce_n_in = 1, oe_n_in = 1, fail_mode = 0;
	logic chip_op_busy_in = 0, supply_low_in = 0, block_locked_in = 0, buffer_avail_in = 0;
	logic [3:0]      prog_err_in = 4'h0, erase_susp_in = 4'h0;
	logic [3:0]      prog_busy_in = 4'h0, prog_susp_in = 4'h0;
	fpse_bus_t       bus_in = '0;
	logic [15:0]     rdata_out;
	logic            dq_oe_n_out, erase_start_out, engine_busy_in, engine_done_in, erase_fail_in;
	fpse_erase_req_t erase_req_out;
	int              fails = 0, samples_checked = 0;

	initial forever #2.5 ref_clk_in = ~ref_clk_in;

	fpse_sequencer u_fpse_sequencer (.ref_clk_in, .rstn_in, .clk_en_in(1'b1), .bus_in,
		.wr_en_in, .ce_n_in, .oe_n_in, .array_data_in(bus_in.addr[15:0] ^ 16'h5a5a),
		.query_data_in(~bus_in.addr[15:0]), .engine_busy_in, .engine_done_in, .erase_fail_in,
		.chip_op_busy_in, .prog_busy_in, .prog_err_in, .erase_susp_in,
		.prog_susp_in, .supply_low_in, .block_locked_in, .buffer_avail_in, .rdata_out,
		.dq_oe_n_out, .erase_start_out, .erase_req_out);
	fpse_engine_model u_fpse_engine_model (.ref_clk_in, .rstn_in, .start_in(erase_start_out),
		.fail_mode_in(fail_mode), .busy_out(engine_busy_in), .done_out(engine_done_in),
		.fail_out(erase_fail_in));

	// ==========================================================
	// Bus cycles
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [20:0] a, input logic [7:0] c);
		@(posedge ref_clk_in);
		bus_in <= {a, 8'h00, c};
		wr_en_in <= 1'b1;
		@(posedge ref_clk_in);
		wr_en_in <= 1'b0;
	endtask
	task automatic rd(input logic [20:0] a, input logic [15:0] e);
		int n;
		@(posedge ref_clk_in);
		bus_in.addr <= a;
		ce_n_in <= 1'b0;
		oe_n_in <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end while (dq_oe_n_out !== 1'b0 && n < 8);
		if (dq_oe_n_out !== 1'b0) begin
			fails++;
			close_out();
		end
		`CHK(rdata_out, e)
		@(posedge ref_clk_in);
		ce_n_in <= 1'b1;
		oe_n_in <= 1'b1;
	endtask
	// Waits past the launch latency before polling the engine
	task automatic wait_idle();
		int n;
		repeat (3) @(posedge ref_clk_in);
		for (n = 0; n < 200 && engine_busy_in !== 1'b0; n++) @(posedge ref_clk_in);
		if (n == 200) begin
			fails++;
			close_out();
		end
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		repeat (6) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		rd(P0, P0[15:0] ^ 16'h5a5a);
		wr(P1, CMD_READ_STATUS);
		rd(P1, RDY);
		rd(P0, P0[15:0] ^ 16'h5a5a);
		wr(P2, CMD_READ_QUERY);
		rd(P2, ~P2[15:0]);
		wr(P2, CMD_READ_ARRAY);
		rd(P2, P2[15:0] ^ 16'h5a5a);
		wr(P3, CMD_ERASE_SETUP);
		wr(P3, CMD_CONFIRM);
		rd(P3, 16'h0000);
		rd(P0, P0[15:0] ^ 16'h5a5a);
		wr(P3, CMD_READ_QUERY);
		rd(P3, 16'h0000);
		wr(P0, CMD_READ_QUERY);
		rd(P0, ~P0[15:0]);
		wait_idle();
		rd(P3, RDY);
		wr(P3, CMD_ERASE_SETUP);
		wr(P3 + 21'h1, CMD_CONFIRM);
		rd(P3, RDY | EE | PE);
		wr(P3, CMD_READ_STATUS);
		rd(P3, RDY | EE | PE);
		erase_susp_in <= 4'h8;
		wr(P3, CMD_CLEAR_STATUS);
		rd(P3, RDY | ES | EE | PE);
		erase_susp_in <= 4'h0;
		wr(P3, CMD_CLEAR_STATUS);
		rd(P3, P3[15:0] ^ 16'h5a5a);
		for (int i = 0; i < 3; i++) begin
			supply_low_in <= (i == 0);
			block_locked_in <= (i == 1);
			fail_mode <= (i == 2);
			wr(P2, CMD_ERASE_SETUP);
			wr(P2, CMD_CONFIRM);
			wait_idle();
			rd(P2, RDY | EE | (i == 0 ? SL : i == 1 ? LK : 16'h0));
			wr(P2, CMD_CLEAR_STATUS);
		end
		buffer_avail_in <= 1'b1;
		wr(P1, CMD_PAGE_BUFFER);
		rd(P1, BUF);
		buffer_avail_in <= 1'b0;
		wr(P1, CMD_PAGE_BUFFER);
		rd(P1, 16'h0000);
		chip_op_busy_in <= 1'b1;
		erase_susp_in <= 4'h4;
		wr(P0, CMD_READ_ARRAY);
		wr(P0, CMD_READ_QUERY);
		rd(P2, ES);
		chip_op_busy_in <= 1'b0;
		erase_susp_in <= 4'h0;
		rd(P0, P0[15:0] ^ 16'h5a5a);
		// Program busy on one partition refuses query unless suspended
		prog_busy_in <= 4'h2;
		wr(P1, CMD_READ_QUERY);
		rd(P1, 16'h0000);
		prog_busy_in <= 4'h0;
		rd(P1, 16'h0000);
		prog_busy_in <= 4'h2;
		prog_susp_in <= 4'h2;
		wr(P1, CMD_READ_QUERY);
		prog_busy_in <= 4'h0;
		rd(P1, ~P1[15:0]);
		wr(P1, CMD_READ_STATUS);
		wr(P1, CMD_CLEAR_STATUS);
		rd(P1, RDY | PS);
		prog_susp_in <= 4'h0;
		prog_err_in <= 4'h1;
		@(posedge ref_clk_in);
		prog_err_in <= 4'h0;
		wr(P0, CMD_READ_STATUS);
		rd(P0, RDY | PE);
		close_out();
	end
endmodule
`default_nettype wire
